// ### hw/cie_cfg_target.sv
// Contract
// R01 - one irq pin, each event maskable
// R02 - link restart clears four event flags
// R03 - link restart dropping link sets link_off
// R04 - env_on event mirrors link status level
// R05 - any link enable sets link_on
// R06 - scratch write/read and remote done events
// R07 - separate sleep, pairing, thermal, power faults
// R08 - standard, fast and fast-plus rates
// R09 - no glitch filter, clean scl required
// R10 - answer only fixed target address
// R11 - controller sends address, index, data
// R12 - write data auto-increments register index
// R13 - ack every byte until stop
// R14 - controller sets index then restarts reading
// R15 - read auto-increments while controller acks
// R16 - start in sleep requests internal clock
// R17 - drop clock request after access ends
// R18 - remote registers readable only with link
// R19 - remote writes allowed, consistency is controller's
// R20 - controller avoids writes while searching/bridging
// R21 - controller configures during sleep beforehand
// R22 - flags sticky, irq is OR of enabled
`include "cie_regs.svh"
module cie_cfg_target import cie_pkg::*; #(
  parameter int SCRATCH_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_sleep,
  output logic o_clk_req,
  input wire logic i_link_status,
  input wire logic i_link_restart,
  input wire logic i_link_enabled,
  input wire logic i_remote_done,
  input wire logic i_sleep_fail,
  input wire logic i_pairing_fail,
  input wire logic i_thermal_fault,
  input wire logic i_bridging_entry,
  input wire logic i_sleep_entry,
  input wire logic i_sig_done,
  input wire logic i_sig_fault,
  input wire logic i_pcomp_fault,
  input wire logic [7:0] i_remote_rdata,
  output logic [6:0] o_remote_idx,
  output logic o_remote_we,
  output logic [7:0] o_remote_wdata,
  output logic o_link_enable_req,
  output logic o_link_restart_req,
  output logic o_sleep_cmd,
  output logic o_irq
);
  localparam int SCR_AW = (SCRATCH_DEPTH > 1) ? $clog2(SCRATCH_DEPTH) : 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic in_scr(input logic [7:0] a);
    in_scr = (a >= `CIE_IDX_SCR_BASE) && (a < `CIE_IDX_SCR_BASE + 8'(SCRATCH_DEPTH));
  endfunction : in_scr

  function automatic logic [7:0] cie_rd(input logic [7:0] a, input cie_evt_type ev, input cie_evt_type mk,
                                        input logic [7:0] st, input logic [7:0] sc, input logic [7:0] rm,
                                        input logic lk);
    logic [15:0] e16;
    logic [15:0] m16;
    e16 = 16'(ev);
    m16 = 16'(mk);
    cie_rd = `CIE_BYTE_RST;
    if (a[`CIE_IDX_REMOTE_BIT]) begin
      cie_rd = lk ? rm : `CIE_BYTE_RST; // R18
    end else if (in_scr(a)) begin
      cie_rd = sc;
    end else begin
      case (a)
        `CIE_IDX_EVT_LO: cie_rd = e16[7:0];
        `CIE_IDX_EVT_HI: cie_rd = e16[15:8];
        `CIE_IDX_MASK_LO: cie_rd = m16[7:0];
        `CIE_IDX_MASK_HI: cie_rd = m16[15:8];
        `CIE_IDX_STAT: cie_rd = st;
        default: cie_rd = `CIE_BYTE_RST;
      endcase
    end
  endfunction : cie_rd

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic rise, fall, start, stop;

  // two flops per pin, third stage only for edge detection
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
    end
  end

  // sampled straight on scl edges, no filter: a glitch is a clock edge
  assign rise = scl_s & ~scl_d; // R09
  assign fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------
  // serial target engine
  // ----------------------------------------
  cie_state_type state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] shift, next_shift, idx, next_idx, rdata, wdat;
  logic first, next_first, rd_dir, next_rd_dir, oe, next_oe, clk_req, next_clk_req;
  logic wr_strobe, rd_load;
  logic [7:0] stat;
  logic [7:0] scratch [SCRATCH_DEPTH];
  cie_evt_type evt, view, mask;

  assign wdat = {shift[6:0], sda_s};
  assign stat = {5'h00, clk_req, i_sleep, i_link_status};
  assign rdata = cie_rd(idx, view, mask, stat, scratch[SCR_AW'(idx - `CIE_IDX_SCR_BASE)], i_remote_rdata,
                        i_link_status);

  // byte framing, ack driving and index handling
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_idx = idx;
    next_first = first;
    next_rd_dir = rd_dir;
    next_oe = oe;
    next_clk_req = clk_req;
    wr_strobe = 1'b0;
    rd_load = 1'b0;
    if (start) begin
      next_state = PH_ADDR;
      next_cnt = 3'h0;
      next_oe = 1'b0;
      if (i_sleep) begin
        next_clk_req = 1'b1; // R16
      end
    end else if (stop) begin
      next_state = PH_IDLE;
      next_oe = 1'b0;
      next_clk_req = 1'b0; // R17
    end else if (rise) begin
      unique case (state)
        PH_ADDR, PH_WR: begin
          next_shift = wdat;
          next_cnt = cnt + 3'h1;
          if (cnt == `CIE_LAST_BIT) begin
            if (state == PH_ADDR) begin
              next_rd_dir = sda_s;
              next_first = 1'b1;
              next_state = (shift[6:0] == `CIE_TGT_ADDR) ? PH_AACK : PH_SKIP; // R10
            end else begin
              next_state = PH_WACK; // R13
              if (first) begin
                next_first = 1'b0;
                next_idx = wdat;
              end else begin
                wr_strobe = 1'b1;
                next_idx = idx + 8'h01; // R12
              end
            end
          end
        end
        PH_RD: begin
          next_shift = {shift[6:0], 1'b0};
          next_cnt = cnt + 3'h1;
          if (cnt == `CIE_LAST_BIT) begin
            next_state = PH_RACK;
            next_idx = idx + 8'h01; // R15
          end
        end
        PH_RACK: begin
          if (!sda_s) begin
            next_state = PH_RD; // R15
            next_shift = rdata;
            rd_load = 1'b1;
          end else begin
            next_state = PH_SKIP;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      unique case (state)
        PH_AACK, PH_WACK: begin
          if (!oe) begin
            next_oe = 1'b1; // R13
          end else if (state == PH_AACK && rd_dir) begin
            next_state = PH_RD;
            next_shift = rdata;
            next_oe = ~rdata[7];
            rd_load = 1'b1;
          end else begin
            next_oe = 1'b0;
            next_state = PH_WR;
          end
        end
        PH_RD: next_oe = ~shift[7];
        PH_RACK: next_oe = 1'b0;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= PH_IDLE;
      cnt <= 3'h0;
      shift <= `CIE_BYTE_RST;
      idx <= `CIE_BYTE_RST;
      first <= 1'b0;
      rd_dir <= 1'b0;
      oe <= 1'b0;
      clk_req <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      idx <= next_idx;
      first <= next_first;
      rd_dir <= next_rd_dir;
      oe <= next_oe;
      clk_req <= next_clk_req;
    end
  end

  // open drain: only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe;
  assign o_clk_req = clk_req;
  assign o_remote_idx = idx[6:0];

  // ----------------------------------------
  // register file and events
  // ----------------------------------------
  cie_evt_type next_evt, next_mask, set, clr;
  logic next_irq, irq, pend, wr_lo, wr_hi;
  logic next_le, next_lr, next_sc, next_rwe;
  logic le, lr, sc, rwe;
  logic [7:0] next_rwd, rwd;

  // env_on is a live level, not a latched flag
  always_comb begin
    view = evt;
    view[`CIE_ENV_ON_LEVEL_EVENT] = i_link_status; // R04
  end

  assign pend = |(view & mask); // R01 R22

  // set wins over both software and restart clear
  always_comb begin
    set = `CIE_EVT_RST;
    set[`CIE_SCRATCH_WRITE_EVENT] = wr_strobe & in_scr(idx); // R06
    set[`CIE_SCRATCH_READ_EVENT] = rd_load & in_scr(idx); // R06
    set[`CIE_LINK_ON_EVENT] = i_link_enabled; // R05
    set[`CIE_SLEEP_VALIDATE_FAIL_EVENT] = i_sleep_fail; // R07
    set[`CIE_REMOTE_ACCESS_DONE_EVENT] = i_remote_done; // R06
    set[`CIE_PAIRING_FAIL_EVENT] = i_pairing_fail; // R07
    set[`CIE_LINK_OFF_EVENT] = i_link_restart & i_link_status; // R03
    set[`CIE_THERMAL_FAULT_EVENT] = i_thermal_fault; // R07
    set[`CIE_BRIDGING_ENTRY_EVENT] = i_bridging_entry;
    set[`CIE_SLEEP_ENTRY_EVENT] = i_sleep_entry;
    set[`CIE_SIGNAL_STRENGTH_DONE] = i_sig_done;
    set[`CIE_SIGNAL_STRENGTH_FAULT] = i_sig_fault;
    set[`CIE_POWER_COMP_FAULT_EVENT] = i_pcomp_fault; // R07
    wr_lo = wr_strobe && (idx == `CIE_IDX_EVT_LO);
    wr_hi = wr_strobe && (idx == `CIE_IDX_EVT_HI);
    clr = `CIE_EVT_W'({wr_hi ? wdat : 8'h00, wr_lo ? wdat : 8'h00});
    next_evt = (evt & ~clr & ~(i_link_restart ? `CIE_EVT_RESTART_CLR : `CIE_EVT_RST)) | set; // R02 R22
    next_mask = mask;
    if (wr_strobe && idx == `CIE_IDX_MASK_LO) begin
      next_mask = (mask & ~`CIE_EVT_W'(16'h00ff)) | `CIE_EVT_W'({8'h00, wdat});
    end
    if (wr_strobe && idx == `CIE_IDX_MASK_HI) begin
      next_mask = (mask & `CIE_EVT_W'(16'h00ff)) | `CIE_EVT_W'({wdat, 8'h00});
    end
    next_irq = pend; // R01
    next_le = wr_strobe && idx == `CIE_IDX_CTRL && wdat[`CIE_CTRL_LINK_EN];
    next_lr = wr_strobe && idx == `CIE_IDX_CTRL && wdat[`CIE_CTRL_RESTART];
    next_sc = wr_strobe && idx == `CIE_IDX_CTRL && wdat[`CIE_CTRL_SLEEP];
    next_rwe = wr_strobe && idx[`CIE_IDX_REMOTE_BIT] && i_link_status; // R19
    next_rwd = next_rwe ? wdat : rwd;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      evt <= `CIE_EVT_RST;
      mask <= `CIE_MASK_RST;
      irq <= 1'b0;
      le <= 1'b0;
      lr <= 1'b0;
      sc <= 1'b0;
      rwe <= 1'b0;
      rwd <= `CIE_BYTE_RST;
      for (int i = 0; i < SCRATCH_DEPTH; i++) begin
        scratch[i] <= `CIE_BYTE_RST;
      end
    end else begin
      evt <= next_evt;
      mask <= next_mask;
      irq <= next_irq;
      le <= next_le;
      lr <= next_lr;
      sc <= next_sc;
      rwe <= next_rwe;
      rwd <= next_rwd;
      if (wr_strobe && in_scr(idx)) begin
        scratch[SCR_AW'(idx - `CIE_IDX_SCR_BASE)] <= wdat;
      end
    end
  end

  assign o_irq = irq;
  assign o_link_enable_req = le;
  assign o_link_restart_req = lr;
  assign o_sleep_cmd = sc;
  assign o_remote_we = rwe;
  assign o_remote_wdata = rwd;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  irq_or_a: assert property (o_irq == $past(pend)) else $error("irq not OR of enabled flags"); // R01
  restart_clr_a: assert property (i_link_restart && !(|(set & `CIE_EVT_RESTART_CLR))
    |=> (evt & `CIE_EVT_RESTART_CLR) == `CIE_EVT_RST) else $error("restart left flag set"); // R02
  restart_keep_a: assert property (i_link_restart && !wr_strobe
    |=> (evt & ~`CIE_EVT_RESTART_CLR) == (($past(evt) | $past(set)) & ~`CIE_EVT_RESTART_CLR))
    else $error("restart disturbed other flag"); // R02
  link_off_a: assert property (i_link_restart && i_link_status |=> evt[`CIE_LINK_OFF_EVENT])
    else $error("link off not set"); // R03
  env_level_a: assert property (view[`CIE_ENV_ON_LEVEL_EVENT] == i_link_status)
    else $error("env level mismatch"); // R04
  link_on_a: assert property (i_link_enabled |=> evt[`CIE_LINK_ON_EVENT]) else $error("link on lost"); // R05
  remote_done_a: assert property (i_remote_done |=> evt[`CIE_REMOTE_ACCESS_DONE_EVENT])
    else $error("remote done lost"); // R06
  thermal_flag_a: assert property (i_thermal_fault |=> evt[`CIE_THERMAL_FAULT_EVENT])
    else $error("thermal fault lost"); // R07
  addr_ack_a: assert property (rise && state == PH_ADDR && cnt == `CIE_LAST_BIT && shift[6:0] == `CIE_TGT_ADDR
    |=> state == PH_AACK ##[1:1000] o_sda_oe) else $error("address not acked"); // R10
  wr_incr_a: assert property (wr_strobe |=> idx == 8'($past(idx) + 8'h01)) else $error("index not advanced"); // R12
  wake_req_a: assert property (start && i_sleep |=> o_clk_req) else $error("no clock request"); // R16
  sleep_back_a: assert property (stop |=> !o_clk_req) else $error("clock request held"); // R17
endmodule : cie_cfg_target

// ### hw/cie_regs.svh
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH
// ----------------------------------------
// target address and register indexes
// ----------------------------------------
`define CIE_TGT_ADDR 7'h60
`define CIE_IDX_EVT_LO 8'h00
`define CIE_IDX_EVT_HI 8'h01
`define CIE_IDX_MASK_LO 8'h02
`define CIE_IDX_MASK_HI 8'h03
`define CIE_IDX_CTRL 8'h04
`define CIE_IDX_STAT 8'h05
`define CIE_IDX_SCR_BASE 8'h10
`define CIE_IDX_REMOTE_BIT 7
// ----------------------------------------
// control bits, reset values, counts
// ----------------------------------------
`define CIE_CTRL_LINK_EN 0
`define CIE_CTRL_RESTART 1
`define CIE_CTRL_SLEEP 2
`define CIE_LAST_BIT 3'h7
`define CIE_EVT_W 14
`define CIE_EVT_RST 14'h0000
`define CIE_MASK_RST 14'h0000
`define CIE_BYTE_RST 8'h00
// ----------------------------------------
// event bit positions
// ----------------------------------------
`define CIE_SCRATCH_WRITE_EVENT 0
`define CIE_SCRATCH_READ_EVENT 1
`define CIE_LINK_ON_EVENT 2
`define CIE_ENV_ON_LEVEL_EVENT 3
`define CIE_SLEEP_VALIDATE_FAIL_EVENT 4
`define CIE_REMOTE_ACCESS_DONE_EVENT 5
`define CIE_PAIRING_FAIL_EVENT 6
`define CIE_LINK_OFF_EVENT 7
`define CIE_THERMAL_FAULT_EVENT 8
`define CIE_BRIDGING_ENTRY_EVENT 9
`define CIE_SLEEP_ENTRY_EVENT 10
`define CIE_SIGNAL_STRENGTH_DONE 11
`define CIE_SIGNAL_STRENGTH_FAULT 12
`define CIE_POWER_COMP_FAULT_EVENT 13
`define CIE_EVT_RESTART_CLR 14'h0027
// ----------------------------------------
// timing: fastest bit rate against clock
// ----------------------------------------
`define CIE_SYS_CLK_NS 40
`define CIE_FMP_BIT_NS 1000
`define CIE_FMP_BIT_CYC (`CIE_FMP_BIT_NS / `CIE_SYS_CLK_NS)
`endif

// ### hw/cie_pkg.sv
`include "cie_regs.svh"
package cie_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_AACK, PH_WR, PH_WACK, PH_RD, PH_RACK, PH_SKIP} cie_state_type;
  typedef logic [`CIE_EVT_W-1:0] cie_evt_type;
endpackage : cie_pkg

// ### tb/cie_i2c_host.sv
// ----------------------------------------
// host side controller of the config bus
// ----------------------------------------
module cie_i2c_host (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  input wire logic [7:0] i_quarter,
  output logic o_scl,
  output logic o_sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idle: both lines released to their pull-ups
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // every change lands just after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  // scl toggles here and in start_cond and stop_cond, one clean step each way, since the target has no filter
  task automatic clk_pulse(output logic smp);
    tick(int'(i_quarter));
    o_scl = 1'b1;
    tick(int'(i_quarter));
    smp = i_sda;
    tick(int'(i_quarter));
    o_scl = 1'b0;
    tick(int'(i_quarter));
  endtask : clk_pulse

  // release sda first so a repeated start never raises sda while scl is high
  task automatic start_cond();
    o_sda_pull = 1'b0;
    tick(int'(i_quarter));
    o_scl = 1'b1;
    tick(int'(i_quarter));
    o_sda_pull = 1'b1;
    tick(int'(i_quarter));
    o_scl = 1'b0;
    tick(int'(i_quarter));
  endtask : start_cond

  task automatic stop_cond();
    o_sda_pull = 1'b1;
    tick(int'(i_quarter));
    o_scl = 1'b1;
    tick(int'(i_quarter));
    o_sda_pull = 1'b0;
    tick(int'(i_quarter));
  endtask : stop_cond

  // msb first, then sda released for the target's ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      o_sda_pull = ~b[i];
      clk_pulse(smp);
    end
    o_sda_pull = 1'b0;
    clk_pulse(ack);
  endtask : send_byte

  // a high ack tells the target to stop sending
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic smp;
    o_sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_pulse(b[i]);
    end
    o_sda_pull = ~nack;
    clk_pulse(smp);
  endtask : get_byte
endmodule : cie_i2c_host

// ### tb/test_cfg_i2c_target_and_event_irq.sv
`include "cie_regs.svh"
module test_cfg_i2c_target_and_event_irq;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic scl, sda_pull, sda_oe, sda_line, sleep, link_up, clk_req, irq, rem_we, we_seen;
  logic en_req, rst_req, slp_cmd;
  logic [10:0] pulse;
  logic [6:0] rem_idx;
  logic [7:0] rem_rdata, rem_wdata, we_data, quarter;
  logic [2:0] ctl_seen;
  logic [31:0] lfsr_state = 32'hc00c5312;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  logic [7:0] rates [3] = '{8'h3f, 8'h10, 8'h07};
  int n_mismatch = 0;
  int check_count = 0;

  always #20 i_sys_clk = ~i_sys_clk;
  // open-drain wire with pull-up: low while either side pulls
  assign sda_line = ~(sda_pull | sda_oe);
  // remote registers answer a value derived from their index
  assign rem_rdata = {1'b1, rem_idx} ^ 8'h3c;

  // ----------------------------------------
  // design, host and pulse catchers
  // ----------------------------------------
  cie_cfg_target dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line), .o_sda_out(),
    .o_sda_oe(sda_oe), .i_sleep(sleep), .o_clk_req(clk_req), .i_link_status(link_up),
    .i_link_restart(pulse[0]), .i_link_enabled(pulse[1]), .i_remote_done(pulse[2]), .i_sleep_fail(pulse[3]),
    .i_pairing_fail(pulse[4]), .i_thermal_fault(pulse[5]), .i_bridging_entry(pulse[6]),
    .i_sleep_entry(pulse[7]), .i_sig_done(pulse[8]), .i_sig_fault(pulse[9]), .i_pcomp_fault(pulse[10]),
    .i_remote_rdata(rem_rdata), .o_remote_idx(rem_idx), .o_remote_we(rem_we), .o_remote_wdata(rem_wdata),
    .o_link_enable_req(en_req), .o_link_restart_req(rst_req), .o_sleep_cmd(slp_cmd), .o_irq(irq));
  cie_i2c_host host_u (.i_sys_clk(i_sys_clk), .i_sda(sda_line), .i_quarter(quarter), .o_scl(scl),
    .o_sda_pull(sda_pull));

  // pulses last one cycle, so they are caught into sticky flags
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_seen <= 3'h0;
      we_seen <= 1'b0;
      we_data <= 8'h00;
    end else begin
      ctl_seen <= ctl_seen | {slp_cmd, rst_req, en_req};
      if (rem_we) begin
        we_seen <= 1'b1;
        we_data <= rem_wdata;
      end
    end
  end

  // ----------------------------------------
  // bench helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic fire(input logic [10:0] m);
    pulse = m;
    tick(1);
    pulse = 11'h000;
    tick(1);
  endtask : fire

  task automatic wr_regs(input logic [7:0] idx, input int n);
    logic ack;
    host_u.start_cond();
    host_u.send_byte({`CIE_TGT_ADDR, 1'b0}, ack);
    chk_bit(ack, 1'b0);
    host_u.send_byte(idx, ack);
    chk_bit(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      host_u.send_byte(wbuf[i], ack);
      chk_bit(ack, 1'b0);
    end
    host_u.stop_cond();
  endtask : wr_regs

  // index is set by a write ending in stop, then a fresh read transfer
  task automatic rd_regs(input logic [7:0] idx, input int n);
    logic ack;
    wr_regs(idx, 0);
    host_u.start_cond();
    host_u.send_byte({`CIE_TGT_ADDR, 1'b1}, ack);
    chk_bit(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      host_u.get_byte(i == n - 1, rbuf[i]);
    end
    host_u.stop_cond();
  endtask : rd_regs

  task automatic chk_evt(input logic [13:0] exp);
    rd_regs(`CIE_IDX_EVT_LO, 2);
    chk_byte(rbuf[0], exp[7:0]);
    chk_byte(rbuf[1], {2'b00, exp[13:8]});
  endtask : chk_evt

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic ack;
    logic [7:0] base;
    sleep = 1'b0;
    link_up = 1'b0;
    pulse = 11'h000;
    quarter = 8'h07;
    tick(6);
    i_rstn = 1'b1;
    chk_bit(irq, 1'b0);
    chk_bit(sda_oe, 1'b0);
    chk_bit(clk_req, 1'b0);
    tick(3);
    // random scratch bursts at each bit rate
    for (int r = 0; r < 3; r++) begin
      quarter = rates[r];
      lfsr_state = lfsr_next(lfsr_state);
      base = 8'h10 + {6'h00, lfsr_state[1:0]};
      for (int i = 0; i < 4; i++) begin
        lfsr_state = lfsr_next(lfsr_state);
        wbuf[i] = lfsr_state[7:0];
      end
      wr_regs(base, 4);
      rd_regs(base, 4);
      for (int i = 0; i < 4; i++) begin
        chk_byte(rbuf[i], wbuf[i]);
      end
    end
    // events: clear, raise every source, then restart the link
    wbuf[0] = 8'hff;
    wbuf[1] = 8'hff;
    wr_regs(`CIE_IDX_EVT_LO, 2);
    chk_evt(14'h0000);
    fire(11'h7fe);
    wbuf[0] = 8'ha5;
    wr_regs(8'h17, 1);
    chk_evt(14'h3f75);
    rd_regs(8'h17, 1);
    link_up = 1'b1;
    chk_evt(14'h3f7f);
    fire(11'h001);
    link_up = 1'b0;
    chk_evt(14'h3fd0);
    // interrupt pin follows masked flags until they are cleared
    chk_bit(irq, 1'b0);
    wbuf[0] = 8'h20;
    wr_regs(`CIE_IDX_MASK_HI, 1);
    tick(3);
    chk_bit(irq, 1'b1);
    wbuf[0] = 8'h00;
    wr_regs(`CIE_IDX_MASK_HI, 1);
    wbuf[0] = 8'h10;
    wr_regs(`CIE_IDX_MASK_LO, 1);
    tick(3);
    chk_bit(irq, 1'b1);
    wr_regs(`CIE_IDX_EVT_LO, 1);
    tick(3);
    chk_bit(irq, 1'b0);
    // remote window only answers with the link up
    rd_regs(8'h85, 1);
    chk_byte(rbuf[0], 8'h00);
    link_up = 1'b1;
    rd_regs(8'h85, 2);
    chk_byte(rbuf[0], 8'h85 ^ 8'h3c);
    chk_byte(rbuf[1], 8'h86 ^ 8'h3c);
    lfsr_state = lfsr_next(lfsr_state);
    wbuf[0] = lfsr_state[7:0];
    wr_regs(8'h90, 1);
    tick(2);
    chk_bit(we_seen, 1'b1);
    chk_byte(we_data, wbuf[0]);
    link_up = 1'b0;
    // control writes become request pulses
    wbuf[0] = 8'h07;
    wr_regs(`CIE_IDX_CTRL, 1);
    tick(2);
    chk_byte({5'h00, ctl_seen}, 8'h07);
    // foreign address is ignored until stop
    host_u.start_cond();
    host_u.send_byte(8'hc4, ack);
    chk_bit(ack, 1'b1);
    host_u.send_byte(8'h00, ack);
    chk_bit(ack, 1'b1);
    host_u.stop_cond();
    // a start in sleep wakes the clock for this access only
    sleep = 1'b1;
    host_u.start_cond();
    chk_bit(clk_req, 1'b1);
    host_u.send_byte(8'hc0, ack);
    host_u.send_byte(8'h11, ack);
    host_u.stop_cond();
    tick(5);
    chk_bit(clk_req, 1'b0);
    sleep = 1'b0;
    close_out();
  end

  // hang guard: the whole run fits well inside this bound
  initial begin
    repeat (95000) @(posedge i_sys_clk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    close_out();
  end
endmodule : test_cfg_i2c_target_and_event_irq
